//--- rtl/fet_fault_temp_reporting.sv
// Functional notes
// - Switch overheat: conduct third quadrant only
// - Driver overheat: rails and switch off
// - Driver overheat blocks diode emulation
// - Fault low on either thermal shutdown
// - Auto release after both shutdowns clear
// - Driver clears, switch hot: emulation resumes
// - Undervoltage: switch off, fault low
// - Rails enabled on supply-good rising edge
// - Both flags push-pull, high when normal; overcurrent flag left undriven when strapped low
// - Encode fault pair per fault type
// - Fault low until series transistor on
// - Fault low while strength pin open
// - Short/overtemp hold fault until cleared
// - Grounded flag at power-up: fault only
// - Protection independent of reporting pins
// - Strength pin selects turn-on slew
// - Aux strap checked once, then frozen
// - Otherwise strength filtered continuously
// - Temperature PWM at 9 kHz
// - Duty linear in temperature with floor
// - Pin high during overtemperature
// - Short latch cleared by long gate low
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module fet_fault_temp_reporting
  import fet_fault_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PWM_PERIOD_CYC,
  parameter int unsigned SC_CLEAR_CYC = SC_RESET_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire sense_type i_sense,
  input wire logic i_gate_cmd,
  input wire logic i_strength_at_aux,
  input wire logic [7:0] i_strength_code,
  input wire logic [TEMP_W-1:0] i_temp_x10,
  input wire logic i_overcurrent_flag_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  output logic o_fault_n,
  output logic o_overcurrent_flag_n,
  output logic o_overcurrent_flag_oe,
  output logic o_temp_pwm,
  output logic o_switch_on,
  output logic o_thermal_diode_emulation,
  output logic o_aux_5v_en,
  output logic o_negative_rail_en,
  output logic [7:0] o_slew_code
);
  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_rst_n); // Checks idle in reset
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  sense_type meta_ff; // First stage, read only by second
  sense_type sync_ff; // Stable copy
  logic supply_prev_ff; // Supply-good last cycle

  // Two-flop resync of all conditions
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      supply_prev_ff <= 1'b0;
    end else begin
      meta_ff <= i_sense;
      sync_ff <= meta_ff;
      supply_prev_ff <= sync_ff.supply_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions
  logic uvlo; // Supply below threshold
  logic drv_ot; // Driver shutdown
  logic sw_ot; // Switch shutdown
  logic thermal_any; // Either shutdown

  assign uvlo = !sync_ff.supply_ok;
  assign drv_ot = sync_ff.driver_ot;
  assign sw_ot = sync_ff.switch_ot;
  assign thermal_any = sw_ot | drv_ot;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up hold
  logic started_ff; // Series transistor seen on

  // Set once the series transistor is on
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      started_ff <= 1'b0;
    end else if (sync_ff.series_fet_on) begin
      started_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rails
  logic rails_ff; // Rails armed since supply rose

  // Armed on supply-good rising edge, dropped on loss
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rails_ff <= 1'b0;
    end else if (sync_ff.supply_ok && !supply_prev_ff) begin
      rails_ff <= 1'b1;
    end else if (uvlo) begin
      rails_ff <= 1'b0;
    end
  end

  // Driver overheat holds both rails off
  assign o_aux_5v_en = rails_ff & !drv_ot;
  assign o_negative_rail_en = rails_ff & !drv_ot;
  property p_driver_rails;
    drv_ot |-> !o_aux_5v_en && !o_negative_rail_en ##1 !o_switch_on;
  endproperty
  a_driver_rails: assert property (p_driver_rails)
    else $error("rails or switch on in driver shutdown");
  property p_rail_rise;
    sync_ff.supply_ok && !supply_prev_ff && !drv_ot |=> o_aux_5v_en;
  endproperty
  a_rail_rise: assert property (p_rail_rise)
    else $error("rails not enabled on supply rise");

  ////////////////////////////////////////////////////////////////////////////
  // Current fault latches
  logic sc_latch_ff; // Latched short circuit
  logic oc_ff; // Cycle-by-cycle overcurrent
  logic [15:0] low_cnt_ff; // Gate-low time
  logic sc_clear; // Gate held low long enough

  assign sc_clear = (low_cnt_ff >= 16'(SC_CLEAR_CYC));

  // Gate-low duration counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      low_cnt_ff <= 16'h0000;
    end else if (i_gate_cmd) begin
      low_cnt_ff <= 16'h0000;
    end else if (!sc_clear) begin
      low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
  end

  // Short latch: set wins; long gate low or supply loss clears
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sc_latch_ff <= 1'b0;
    end else if (sync_ff.sc_detect) begin
      sc_latch_ff <= 1'b1;
    end else if (sc_clear || uvlo) begin
      sc_latch_ff <= 1'b0;
    end
  end

  // Overcurrent clears once the gate command falls
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      oc_ff <= 1'b0;
    end else if (sync_ff.oc_detect) begin
      oc_ff <= 1'b1;
    end else if (!i_gate_cmd) begin
      oc_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch control, independent of any reporting pin
  logic tde; // Thermal diode emulation active
  logic nxt_switch_on; // Switch command

  // Emulation only with switch hot and driver cool
  assign tde = sw_ot & !drv_ot & !uvlo;

  // Choose the gate level for this cycle
  always_comb begin
    if (uvlo || drv_ot || sc_latch_ff || !started_ff) begin
      nxt_switch_on = 1'b0;
    end else if (tde) begin
      // On for third quadrant, off for first
      nxt_switch_on = sync_ff.quad3_current & !sync_ff.quad1_current;
    end else begin
      nxt_switch_on = i_gate_cmd & !oc_ff;
    end
  end

  // Registered gate and mode outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_switch_on <= 1'b0;
      o_thermal_diode_emulation <= 1'b0;
    end else begin
      o_switch_on <= nxt_switch_on;
      o_thermal_diode_emulation <= tde;
    end
  end
  property p_no_tde_drv;
    drv_ot |=> !o_thermal_diode_emulation;
  endproperty
  a_no_tde_drv: assert property (p_no_tde_drv)
    else $error("emulation during driver shutdown");
  property p_tde_resume;
    $fell(drv_ot) && sw_ot && !uvlo |=> o_thermal_diode_emulation;
  endproperty
  a_tde_resume: assert property (p_tde_resume)
    else $error("emulation not resumed");
  property p_tde_quad1;
    tde && sync_ff.quad1_current |=> !o_switch_on;
  endproperty
  a_tde_quad1: assert property (p_tde_quad1)
    else $error("switch on against first quadrant");
  property p_uvlo;
    uvlo |=> !o_switch_on && !o_fault_n;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("undervoltage");

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent pin strap
  strap_state_type strap_ff; // Capture progress
  logic combined_ff; // Flag pin grounded at power-up
  logic strap_aux_ff; // Strength pin tied to aux

  // Sample both straps once, pin undriven while sampling
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_ff <= STRAP_WAIT;
      combined_ff <= 1'b0;
      strap_aux_ff <= 1'b0;
    end else begin
      unique case (strap_ff)
        STRAP_WAIT: strap_ff <= STRAP_SAMPLE;
        STRAP_SAMPLE: begin
          combined_ff <= !i_overcurrent_flag_n;
          strap_aux_ff <= i_strength_at_aux;
          strap_ff <= STRAP_DONE;
        end
        STRAP_DONE: strap_ff <= STRAP_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault reporting
  logic fault_low; // Any reason to pull fault low
  logic oc_low; // Current fault on flag pin

  // Thermal, undervoltage, open pin, start-up, short, overcurrent when combined
  assign fault_low = thermal_any | uvlo | sync_ff.strength_pin_open
    | !started_ff | sc_latch_ff | (combined_ff & oc_ff);
  assign oc_low = sc_latch_ff | oc_ff;

  // Fault push-pull; flag driven only after strapping and not when combined; both high when normal
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fault_n <= 1'b0;
      o_overcurrent_flag_n <= 1'b1;
      o_overcurrent_flag_oe <= 1'b0;
    end else begin
      o_fault_n <= !fault_low;
      o_overcurrent_flag_n <= !oc_low;
      o_overcurrent_flag_oe <= (strap_ff == STRAP_DONE) & !combined_ff;
    end
  end
  property p_thermal_fault;
    thermal_any |=> !o_fault_n;
  endproperty
  a_thermal_fault: assert property (p_thermal_fault)
    else $error("fault not low in thermal shutdown");
  property p_sc_code;
    sync_ff.sc_detect |=> ##1 !o_fault_n && !o_overcurrent_flag_n;
  endproperty
  a_sc_code: assert property (p_sc_code) else $error("short code");
  property p_startup;
    !started_ff |=> !o_fault_n;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up");

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0] shift_ff; // Strength filter depth
  logic [31:0] status; // Live status word

  // Control register write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      shift_ff <= CTRL_SHIFT_RST;
    end else if (i_wr && i_addr == REG_CTRL) begin
      shift_ff <= i_wr_data[CTRL_SHIFT_LSB +: CTRL_SHIFT_W];
    end
  end

  // Status assembly
  always_comb begin
    status = 32'h0000_0000;
    status[ST_FAULT_N] = o_fault_n;
    status[ST_OC_N] = o_overcurrent_flag_n;
    status[ST_TDE] = o_thermal_diode_emulation;
    status[ST_SC_LATCH] = sc_latch_ff;
    status[ST_COMBINED] = combined_ff;
    status[ST_STRAP_AUX] = strap_aux_ff;
    status[ST_SWITCH_ON] = o_switch_on;
    status[ST_RAILS_ON] = o_aux_5v_en;
  end

  // Read data in the cycle after the strobe, else zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_STATUS: o_rd_data <= status;
        REG_CTRL: o_rd_data <= {29'h0000_0000, shift_ff};
        REG_SLEW: o_rd_data <= {24'h00_0000, o_slew_code};
        default: o_rd_data <= 32'h0000_0000;
      endcase
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive strength
  logic [15:0] filt_ff; // Filtered strength, 8.8 fixed point
  logic [15:0] step; // Filter step

  assign step = (16'(i_strength_code) << 8) >> shift_ff;

  // Heavy IIR filter on the strength reading
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      filt_ff <= 16'h0000;
    end else begin
      filt_ff <= filt_ff - (filt_ff >> shift_ff) + step;
    end
  end

  // Aux strap freezes; ground gives fastest; else filtered
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_slew_code <= SLEW_CODE_RST;
    end else if (strap_aux_ff) begin
      o_slew_code <= SLEW_CODE_AUX;
    end else if (filt_ff[15:8] == 8'h00) begin
      o_slew_code <= SLEW_CODE_GND;
    end else begin
      o_slew_code <= filt_ff[15:8];
    end
  end
  property p_aux_frozen;
    strap_aux_ff |=> o_slew_code == SLEW_CODE_AUX;
  endproperty
  a_aux_frozen: assert property (p_aux_frozen)
    else $error("slew not frozen for aux strap");

  ////////////////////////////////////////////////////////////////////////////
  // Temperature PWM
  temp_pwm #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_temp_pwm (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_temp_x10(i_temp_x10),
    .i_over_temp(sw_ot),
    .o_pwm(o_temp_pwm)
  );
endmodule : fet_fault_temp_reporting

//--- rtl/fet_fault_pkg.sv
package fet_fault_pkg;
  // Clock rate
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  // Temperature PWM rate and its period in clock cycles
  localparam int unsigned PWM_FREQ_HZ = 9000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
  // Temperature to duty mapping, temperatures in tenths of a degree
  localparam int unsigned TEMP_SLOPE_X10 = 1623;
  localparam int unsigned TEMP_OFFSET_X10 = 201;
  localparam int unsigned DUTY_FLOOR_PCT = 1;
  localparam int unsigned TEMP_W = 12;
  // Gate-low time that clears a latched short circuit
  localparam int unsigned SC_RESET_TIME_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SC_RESET_CYC =
    (SC_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Slew setting codes
  localparam logic [7:0] SLEW_CODE_GND = 8'hFF;
  localparam logic [7:0] SLEW_CODE_AUX = 8'h80;
  localparam logic [7:0] SLEW_CODE_RST = 8'h00;
  // Register map, byte addresses on the plain port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_SLEW = 4'h8;
  // Control register fields and reset value
  localparam int unsigned CTRL_SHIFT_LSB = 0;
  localparam int unsigned CTRL_SHIFT_W = 3;
  localparam logic [2:0] CTRL_SHIFT_RST = 3'h4;
  // Status register fields
  localparam int unsigned ST_FAULT_N = 0;
  localparam int unsigned ST_OC_N = 1;
  localparam int unsigned ST_TDE = 2;
  localparam int unsigned ST_SC_LATCH = 3;
  localparam int unsigned ST_COMBINED = 4;
  localparam int unsigned ST_STRAP_AUX = 5;
  localparam int unsigned ST_SWITCH_ON = 6;
  localparam int unsigned ST_RAILS_ON = 7;

  // Sensed conditions, one bit each, as they arrive
  typedef struct packed {
    logic switch_ot;
    logic driver_ot;
    logic supply_ok;
    logic series_fet_on;
    logic strength_pin_open;
    logic oc_detect;
    logic sc_detect;
    logic quad1_current;
    logic quad3_current;
  } sense_type;

  // Strap capture progress
  typedef enum logic [1:0] {
    STRAP_WAIT,
    STRAP_SAMPLE,
    STRAP_DONE
  } strap_state_type;

  // Duty count for a temperature, scaled to the period in use
  function automatic logic [15:0] temp_to_duty(
    input logic [TEMP_W-1:0] temp_x10,
    input int unsigned period_cyc
  );
    logic [31:0] num;
    logic [31:0] duty;
    num = 32'h0000_0000;
    duty = 32'h0000_0000;
    if (32'(temp_x10) > TEMP_OFFSET_X10) begin
      num = (32'(temp_x10) - TEMP_OFFSET_X10) * period_cyc;
      duty = num / TEMP_SLOPE_X10;
    end
    if (duty < period_cyc * DUTY_FLOOR_PCT / 100) begin
      duty = period_cyc * DUTY_FLOOR_PCT / 100;
    end
    if (duty > period_cyc - 1) begin
      duty = period_cyc - 1;
    end
    return duty[15:0];
  endfunction : temp_to_duty
endpackage : fet_fault_pkg

//--- rtl/temp_pwm.sv
`timescale 1ns/10ps
module temp_pwm
  import fet_fault_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PWM_PERIOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [TEMP_W-1:0] i_temp_x10,
  input wire logic i_over_temp,
  output logic o_pwm
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cnt_ff; // Free-running period counter
  logic [15:0] duty_ff; // Duty count, loaded at period start
  logic wrap; // Last cycle of a period

  assign wrap = (cnt_ff == 16'(PERIOD_CYC - 1));

  // Free-running counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= 16'h0000;
    end else if (wrap) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // Duty reload only at the boundary, so no runt pulses
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      duty_ff <= 16'h0000;
    end else if (wrap) begin
      duty_ff <= temp_to_duty(i_temp_x10, PERIOD_CYC);
    end
  end

  // Compare; overtemperature forces the pin high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pwm <= 1'b0;
    end else begin
      o_pwm <= i_over_temp | (cnt_ff < duty_ff);
    end
  end
endmodule : temp_pwm

//--- test/psu_ctrl_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Supply controller on the far side of the fault and gate pins
module psu_ctrl_model (
  input wire logic i_clk,
  input wire logic i_gate_req,
  input wire logic i_strap_low,
  input wire logic i_fault_n,
  input wire logic i_flag_n,
  input wire logic i_flag_oe,
  output logic o_gate_cmd,
  output logic o_flag_pin,
  output logic [1:0] o_fault_kind
);
  ////////////////////////////////////////////////////////////////////////////
  // Flag wire: device driver, else strap to ground, else board pull-up
  assign o_flag_pin = i_flag_oe ? i_flag_n : !i_strap_low;

  // Gate command changes just after an edge; long low clears a latch
  always_ff @(posedge i_clk) begin
    o_gate_cmd <= i_gate_req;
  end

  // Decoded fault pair; flag ignored when strapped to combined mode
  always_comb begin
    o_fault_kind = {i_fault_n, i_strap_low ? 1'b1 : i_flag_n};
  end
endmodule : psu_ctrl_model

//--- test/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the fault and temperature reporting block
module tb_top;
  import fet_fault_pkg::*;
  localparam int unsigned P = 100; // Short PWM period
  localparam int unsigned SCC = 8; // Short latch clear count
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  sense_type sn = '0; // All sensed conditions
  logic gate_req = 1'b0;
  logic strap_low = 1'b0;
  logic at_aux = 1'b0;
  logic [7:0] code = 8'h00;
  logic [TEMP_W-1:0] temp = 12'h000;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic fault_n, flag_n, flag_oe, pwm, sw_on, tde, aux_en, neg_en;
  logic [7:0] slew;
  logic gate_cmd, flag_pin;
  logic [1:0] kind;
  logic [31:0] d;
  int err_count = 0;
  int num_checks = 0;

  // Clock, 100 MHz
  always #5 i_clk = ~i_clk;

  fet_fault_temp_reporting #(.PERIOD_CYC(P), .SC_CLEAR_CYC(SCC))
  u_fet_fault_temp_reporting (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sense(sn), .i_gate_cmd(gate_cmd),
    .i_strength_at_aux(at_aux), .i_strength_code(code),
    .i_temp_x10(temp), .i_overcurrent_flag_n(flag_pin),
    .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rdata), .o_fault_n(fault_n), .o_overcurrent_flag_n(flag_n),
    .o_overcurrent_flag_oe(flag_oe), .o_temp_pwm(pwm), .o_switch_on(sw_on),
    .o_thermal_diode_emulation(tde), .o_aux_5v_en(aux_en),
    .o_negative_rail_en(neg_en), .o_slew_code(slew)
  );

  psu_ctrl_model u_psu_ctrl_model (
    .i_clk(i_clk), .i_gate_req(gate_req), .i_strap_low(strap_low),
    .i_fault_n(fault_n), .i_flag_n(flag_n), .i_flag_oe(flag_oe),
    .o_gate_cmd(gate_cmd), .o_flag_pin(flag_pin), .o_fault_kind(kind)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wait edges, then let their updates land
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  // One-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : reg_wr

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, supply-good rails, start-up hold
  task automatic t_startup;
    `CHK(fault_n, 1'b0)
    `CHK({sw_on, aux_en, flag_n}, 3'h1)
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    step(5);
    `CHK(fault_n, 1'b0)
    sn.supply_ok <= 1'b1;
    step(5);
    `CHK({aux_en, neg_en}, 2'h3)
    `CHK(fault_n, 1'b0)
    sn.series_fet_on <= 1'b1;
    step(5);
    `CHK({kind, flag_oe}, 3'h7)
    `CHK(slew, SLEW_CODE_GND)
  endtask : t_startup

  // Two-level thermal shutdown sequence
  task automatic t_thermal;
    sn.switch_ot <= 1'b1;
    step(5);
    `CHK({kind, tde, pwm}, 4'h7)
    sn.quad3_current <= 1'b1;
    step(5);
    `CHK(sw_on, 1'b1)
    sn.quad3_current <= 1'b0;
    sn.quad1_current <= 1'b1;
    step(5);
    `CHK(sw_on, 1'b0)
    sn.quad1_current <= 1'b0;
    sn.quad3_current <= 1'b1;
    sn.driver_ot <= 1'b1;
    step(5);
    `CHK({tde, sw_on, aux_en, neg_en}, 4'h0)
    `CHK(fault_n, 1'b0)
    sn.driver_ot <= 1'b0;
    step(5);
    `CHK({tde, fault_n}, 2'h2)
    sn.quad3_current <= 1'b0;
    sn.switch_ot <= 1'b0;
    step(5);
    `CHK({fault_n, tde, aux_en}, 3'h5)
  endtask : t_thermal

  // Undervoltage while switching
  task automatic t_uvlo;
    gate_req <= 1'b1;
    step(5);
    `CHK(sw_on, 1'b1)
    sn.supply_ok <= 1'b0;
    step(5);
    `CHK({sw_on, fault_n}, 2'h0)
    sn.supply_ok <= 1'b1;
    step(5);
    `CHK({aux_en, fault_n}, 2'h3)
  endtask : t_uvlo

  // Overcurrent, then latched short circuit and its gate-low clear
  task automatic t_current;
    sn.oc_detect <= 1'b1;
    step(5);
    `CHK({kind, sw_on}, 3'h4)
    sn.oc_detect <= 1'b0;
    gate_req <= 1'b0;
    step(5);
    `CHK(kind, 2'h3)
    gate_req <= 1'b1;
    sn.sc_detect <= 1'b1;
    step(5);
    sn.sc_detect <= 1'b0;
    step(5);
    `CHK({kind, sw_on}, 3'h0)
    gate_req <= 1'b0;
    step(3);
    gate_req <= 1'b1;
    step(5);
    `CHK({kind, sw_on}, 3'h0)
    gate_req <= 1'b0;
    step(SCC + 4);
    `CHK(kind, 2'h3)
  endtask : t_current

  // Open strength pin, filtered setting, register port
  task automatic t_strength;
    sn.strength_pin_open <= 1'b1;
    step(5);
    `CHK(kind, 2'h1)
    sn.strength_pin_open <= 1'b0;
    reg_rd(REG_CTRL, d);
    `CHK(d, 32'h0000_0004)
    reg_wr(REG_CTRL, 32'h0000_0000);
    reg_rd(REG_CTRL, d);
    `CHK(d, 32'h0000_0000)
    code <= 8'h40;
    step(40);
    `CHK(slew, 8'h40)
    reg_wr(REG_SLEW, 32'h0000_00FF);
    reg_rd(REG_SLEW, d);
    `CHK(d, 32'h0000_0040)
    reg_rd(4'hC, d);
    `CHK(d, 32'h0000_0000)
    reg_rd(REG_STATUS, d);
    `CHK({d[7], d[4], d[1:0]}, 4'hB)
  endtask : t_strength

  // Temperature PWM duty over one full period
  task automatic t_pwm;
    logic [TEMP_W-1:0] tv [3] = '{12'h064, 12'h3E8, 12'h5DC};
    logic [7:0] ex [3] = '{8'h01, 8'h31, 8'h50};
    logic [7:0] hi;
    foreach (tv[k]) begin
      temp <= tv[k];
      step(3 * P);
      hi = 8'h00;
      repeat (P) begin
        step(1);
        hi = hi + {7'h00, pwm};
      end
      `CHK(hi, ex[k])
    end
  endtask : t_pwm

  // Second power-up: flag strapped low, strength tied to aux
  task automatic t_combined;
    i_rst_n <= 1'b0;
    strap_low <= 1'b1;
    at_aux <= 1'b1;
    step(10);
    i_rst_n <= 1'b1;
    step(8);
    `CHK(flag_oe, 1'b0)
    `CHK(slew, SLEW_CODE_AUX)
    code <= 8'h10;
    step(40);
    `CHK(slew, SLEW_CODE_AUX)
    sn.oc_detect <= 1'b1;
    step(5);
    `CHK({fault_n, flag_oe}, 2'h0)
    `CHK(kind, 2'h1)
    sn.oc_detect <= 1'b0;
  endtask : t_combined

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    step(9);
    t_startup();
    t_thermal();
    t_uvlo();
    t_current();
    t_strength();
    t_pwm();
    t_combined();
    give_verdict();
  end

  // Watchdog, well past the expected run length
  initial begin
    #200_000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
